// *** pkg/sp0_pkg.sv ***
// Purpose: Shared constants and types for serial port 0.
// Assumes: APB byte addresses are four times the register index.
// Notes: Timer ticks arrive at sixteen times the bit rate.
//
// Summary of operation
// [RULE1] Two upper mode bits pick modes 0-3.
// [RULE2] Modes 1/3 use timer ticks; 0/2 divider.
// [RULE3] Bit 7 is mode or frame error.
// [RULE4] Bad stop bit sets sticky frame error.
// [RULE5] Mode and frame error stored apart.
// [RULE6] Mode 0 multiprocessor bit picks period.
// [RULE7] Mode 1 filter drops bad-stop frames.
// [RULE8] Modes 2/3 filter need ninth bit one.
// [RULE9] Receive enable gates reception, starts mode 0.
// [RULE10] Modes 2/3 send control ninth bit.
// [RULE11] Ninth bit or stop bit captured.
// [RULE12] Transmit done after last data bit.
// [RULE13] Receive done after last sample; modes 2/3 set it at the ninth bit sample, before the stop sample.
// [RULE14] One address: write transmit, read receive.
// [RULE15] Start low, LSB first, stop high.
package sp0_pkg;
  localparam logic [9:0] CTL_IDX = 10'h098;
  localparam logic [9:0] BUF_IDX = 10'h099;
  localparam logic [9:0] CFG_IDX = 10'h0a0;
  localparam logic [9:0] STAT_IDX = 10'h0a1;
  localparam logic [9:0] MASK_IDX = 10'h0a2;
  localparam logic [11:0] CTL_ADDR = {CTL_IDX, 2'h0};
  localparam logic [11:0] BUF_ADDR = {BUF_IDX, 2'h0};
  localparam logic [11:0] CFG_ADDR = {CFG_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'h0};
  localparam logic [11:0] MASK_ADDR = {MASK_IDX, 2'h0};
  // Control register bit positions.
  localparam int B_MHI = 7;
  localparam int B_MLO = 6;
  localparam int B_MP = 5;
  localparam int B_REN = 4;
  localparam int B_TB8 = 3;
  localparam int B_RB8 = 2;
  localparam int B_TI = 1;
  localparam int B_RI = 0;
  // Configuration and interrupt bit positions.
  localparam int C_FEV = 0;
  localparam int C_M2F = 1;
  localparam int C_T2 = 2;
  localparam int S_TX = 0;
  localparam int S_RX = 1;
  localparam int S_FE = 2;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // Clock counts per mode 0 half bit and per mode 2 oversample tick.
  localparam logic [5:0] SYNC_SLOW = 6'h06;
  localparam logic [5:0] SYNC_FAST = 6'h02;
  localparam logic [5:0] M2_SLOW = 6'h04;
  localparam logic [5:0] M2_FAST = 6'h02;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [1:0] {MODE0 = 2'b00, MODE1 = 2'b01, MODE2 = 2'b10, MODE3 = 2'b11} sp0_mode_type;
  typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_SYNC = 3'b001, TX_START = 3'b010, TX_DATA = 3'b011,
                            TX_NINTH = 3'b100, TX_STOP = 3'b101} sp0_tx_type;
  typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_NINTH = 3'b011,
                            RX_STOP = 3'b100} sp0_rx_type;
endpackage

// *** pkg/sp0_tick_if.sv ***
// Purpose: Carries rate pulses from the baud generator to the port.
// Assumes: Both pulses last one clock cycle.
// Notes: os_tick is the sixteen-times tick, sync_tick the mode 0 half bit.
`timescale 1ns/100ps
interface sp0_tick_if;
  logic os_tick;
  logic sync_tick;
  modport gen  (output os_tick, output sync_tick);
  modport user (input os_tick, input sync_tick);
endinterface

// *** design/sp0_baud_gen.sv ***
// Purpose: Makes the bit rate pulses for every serial mode.
// Assumes: Timer ticks are one-cycle pulses at sixteen times the bit rate.
// Notes: The divider restarts whenever the mode leaves the divided modes.
`timescale 1ns/100ps
module sp0_baud_gen (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire sp0_pkg::sp0_mode_type mode,
  input  wire logic                multiproc,
  input  wire logic                m2_fast,
  input  wire logic                t2_sel,
  input  wire logic                timer1_tick,
  input  wire logic                timer2_tick,
  sp0_tick_if.gen                  tk
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic       os_q;
  logic       os_d;
  logic       sy_q;
  logic       sy_d;

  // Picks the pulse source and period from the mode.
  always_comb begin
    cnt_d = cnt_q + 6'h01;
    os_d = 1'b0;
    sy_d = 1'b0;
    case (mode)
      sp0_pkg::MODE0: begin
        if (cnt_q == (multiproc ? sp0_pkg::SYNC_FAST : sp0_pkg::SYNC_SLOW) - 6'h01) begin // [RULE6]
          cnt_d = 6'h00;
          sy_d = 1'b1;
        end
      end
      sp0_pkg::MODE2: begin
        if (cnt_q == (m2_fast ? sp0_pkg::M2_FAST : sp0_pkg::M2_SLOW) - 6'h01) begin // [RULE2]
          cnt_d = 6'h00;
          os_d = 1'b1;
        end
      end
      default: begin
        cnt_d = 6'h00;
        os_d = t2_sel ? timer2_tick : timer1_tick; // [RULE2]
      end
    endcase
  end

  // Registers the divider and pulses.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
      os_q <= 1'b0;
      sy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      os_q <= os_d;
      sy_q <= sy_d;
    end
  end

  assign tk.os_tick = os_q;
  assign tk.sync_tick = sy_q;
endmodule

// *** design/sp0_serial_port.sv ***
// Purpose: Serial port 0 with APB registers, framing and interrupts.
// Assumes: APB master holds a request until pready; pins are synchronous.
// Notes: In mode 0 txd carries the shift clock and rxd the data.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module sp0_serial_port (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer1_tick,
  input  wire logic        timer2_tick,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             txd,
  output logic             irq
);
  typedef struct packed {
    sp0_pkg::sp0_mode_type mode;
    logic mp, ren, tb8, rb8, ti, ri, fe, fev, m2f, t2;
    logic [2:0] stat, mask;
    logic [7:0] rxbuf, txsh, rxsh;
    sp0_pkg::sp0_tx_type tx_st;
    logic [3:0] tx_ph;
    logic [2:0] tx_cnt;
    logic sync_rx;
    sp0_pkg::sp0_rx_type rx_st;
    logic [3:0] rx_ph;
    logic [2:0] rx_cnt;
    logic txd, rxo, rxoe, irq;
    logic [31:0] prdata;
    logic pready, pslverr;
  } sp0_core_type;

  // Package constants used throughout the port, named once here.
  typedef sp0_pkg::sp0_mode_type sp0_mode_type;
  localparam int B_MHI = sp0_pkg::B_MHI, B_MLO = sp0_pkg::B_MLO, B_MP = sp0_pkg::B_MP, B_REN = sp0_pkg::B_REN;
  localparam int B_TB8 = sp0_pkg::B_TB8, B_RB8 = sp0_pkg::B_RB8, B_TI = sp0_pkg::B_TI, B_RI = sp0_pkg::B_RI;
  localparam int C_FEV = sp0_pkg::C_FEV, C_M2F = sp0_pkg::C_M2F, C_T2 = sp0_pkg::C_T2;
  localparam int S_TX = sp0_pkg::S_TX, S_RX = sp0_pkg::S_RX, S_FE = sp0_pkg::S_FE;
  localparam logic [11:0] CTL_ADDR = sp0_pkg::CTL_ADDR, BUF_ADDR = sp0_pkg::BUF_ADDR, CFG_ADDR = sp0_pkg::CFG_ADDR;
  localparam logic [11:0] STAT_ADDR = sp0_pkg::STAT_ADDR, MASK_ADDR = sp0_pkg::MASK_ADDR;
  localparam logic [7:0] CTL_RESET = sp0_pkg::CTL_RESET;
  localparam logic [2:0] IRQ_RESET = sp0_pkg::IRQ_RESET, BIT_LAST = sp0_pkg::BIT_LAST;
  localparam logic [3:0] OS_MID = sp0_pkg::OS_MID, OS_LAST = sp0_pkg::OS_LAST;
  localparam sp0_mode_type MODE0 = sp0_pkg::MODE0, MODE1 = sp0_pkg::MODE1;
  localparam sp0_pkg::sp0_tx_type TX_IDLE = sp0_pkg::TX_IDLE, TX_SYNC = sp0_pkg::TX_SYNC;
  localparam sp0_pkg::sp0_tx_type TX_START = sp0_pkg::TX_START, TX_DATA = sp0_pkg::TX_DATA;
  localparam sp0_pkg::sp0_tx_type TX_NINTH = sp0_pkg::TX_NINTH, TX_STOP = sp0_pkg::TX_STOP;
  localparam sp0_pkg::sp0_rx_type RX_IDLE = sp0_pkg::RX_IDLE, RX_START = sp0_pkg::RX_START;
  localparam sp0_pkg::sp0_rx_type RX_DATA = sp0_pkg::RX_DATA, RX_NINTH = sp0_pkg::RX_NINTH;
  localparam sp0_pkg::sp0_rx_type RX_STOP = sp0_pkg::RX_STOP;

  sp0_core_type q;
  sp0_core_type n;
  logic         acc;
  logic         wr;
  logic         ev_tx;
  logic         ev_rx;
  logic         ev_fe;
  logic [7:0]   ctl_view;
  logic [7:0]   wb;

  sp0_tick_if tk ();

  // Rate pulses for the shifters.
  sp0_baud_gen u_baud (
    .clk         (clk),
    .rst_n       (rst_n),
    .mode        (q.mode),
    .multiproc   (q.mp),
    .m2_fast     (q.m2f),
    .t2_sel      (q.t2),
    .timer1_tick (timer1_tick),
    .timer2_tick (timer2_tick),
    .tk          (tk)
  );

  // Next state of the registers, shifters and bus answer.
  always_comb begin
    n = q;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    ev_tx = 1'b0;
    ev_rx = 1'b0;
    ev_fe = 1'b0;
    wb = pwdata[7:0];
    acc = psel & penable & ~q.pready;
    wr = psel & penable & q.pready & pwrite;
    ctl_view = {q.mode, q.mp, q.ren, q.tb8, q.rb8, q.ti, q.ri};
    ctl_view[B_MHI] = q.fev ? q.fe : q.mode[1]; // [RULE3]
    // Read data is fetched in the first access cycle, answered next.
    if (acc) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        CTL_ADDR: n.prdata[7:0] = ctl_view;
        BUF_ADDR: n.prdata[7:0] = q.rxbuf; // [RULE14]
        CFG_ADDR: n.prdata[2:0] = {q.t2, q.m2f, q.fev};
        STAT_ADDR: n.prdata[2:0] = q.stat;
        MASK_ADDR: n.prdata[2:0] = q.mask;
        default: n.pslverr = 1'b1;
      endcase
    end
    // Writes land at the edge where pready is seen high.
    if (wr) begin
      case (paddr)
        CTL_ADDR: begin
          if (q.fev) begin
            n.fe = wb[B_MHI]; // [RULE5]
          end else begin
            n.mode[1] = wb[B_MHI]; // [RULE3]
          end
          n.mode[0] = wb[B_MLO];
          n.mp = wb[B_MP];
          n.ren = wb[B_REN];
          n.tb8 = wb[B_TB8];
          n.rb8 = wb[B_RB8];
          n.ti = wb[B_TI];
          n.ri = wb[B_RI];
        end
        BUF_ADDR: begin
          if (q.tx_st == TX_IDLE) begin // [RULE14]
            n.tx_ph = 4'h0;
            n.tx_cnt = 3'h0;
            if (q.mode == MODE0) begin
              n.tx_st = TX_SYNC;
              n.sync_rx = 1'b0;
              n.rxoe = 1'b1;
              n.rxo = wb[0];
              n.txsh = {1'b0, wb[7:1]};
            end else begin
              n.tx_st = TX_START;
              n.txd = 1'b0; // [RULE15]
              n.txsh = wb;
            end
          end
        end
        CFG_ADDR: begin
          n.fev = wb[C_FEV];
          n.m2f = wb[C_M2F];
          n.t2 = wb[C_T2];
        end
        STAT_ADDR: n.stat = q.stat & ~wb[2:0];
        MASK_ADDR: n.mask = wb[2:0];
        default: n.mask = q.mask;
      endcase
    end
    // Mode 0 receive starts when enabled and the last byte was taken.
    if (q.tx_st == TX_IDLE && n.tx_st == TX_IDLE && q.mode == MODE0 && q.ren && !q.ri) begin // [RULE9]
      n.tx_st = TX_SYNC;
      n.sync_rx = 1'b1;
      n.rxoe = 1'b0;
      n.tx_cnt = 3'h0;
      n.tx_ph = 4'h0;
    end
    // Transmit and mode 0 shift engine.
    case (q.tx_st)
      TX_SYNC: begin
        if (tk.sync_tick) begin
          n.tx_ph = q.tx_ph + 4'h1;
          if (!q.tx_ph[0]) begin
            n.txd = 1'b0;
          end else begin
            n.txd = 1'b1;
            if (q.sync_rx) begin
              n.rxsh = {rxd_in, q.rxsh[7:1]};
            end
            if (q.tx_cnt == BIT_LAST) begin
              n.tx_st = TX_IDLE;
              n.rxoe = 1'b0;
              if (q.sync_rx) begin
                n.rxbuf = {rxd_in, q.rxsh[7:1]};
                n.ri = 1'b1; // [RULE13]
                ev_rx = 1'b1;
              end else begin
                n.ti = 1'b1; // [RULE12]
                ev_tx = 1'b1;
              end
            end else begin
              n.tx_cnt = q.tx_cnt + 3'h1;
              n.rxo = q.txsh[0];
              n.txsh = {1'b0, q.txsh[7:1]};
            end
          end
        end
      end
      TX_START, TX_DATA, TX_NINTH, TX_STOP: begin
        if (tk.os_tick) begin
          n.tx_ph = q.tx_ph + 4'h1;
          if (q.tx_ph == OS_LAST) begin
            case (q.tx_st)
              TX_START: begin
                n.tx_st = TX_DATA;
                n.txd = q.txsh[0]; // [RULE15]
                n.txsh = {1'b0, q.txsh[7:1]};
              end
              TX_DATA: begin
                if (q.tx_cnt != BIT_LAST) begin
                  n.tx_cnt = q.tx_cnt + 3'h1;
                  n.txd = q.txsh[0];
                  n.txsh = {1'b0, q.txsh[7:1]};
                end else if (q.mode[1]) begin // [RULE1]
                  n.tx_st = TX_NINTH;
                  n.txd = q.tb8; // [RULE10]
                end else begin
                  n.tx_st = TX_STOP;
                  n.txd = 1'b1;
                  n.ti = 1'b1; // [RULE12]
                  ev_tx = 1'b1;
                end
              end
              TX_NINTH: begin
                n.tx_st = TX_STOP;
                n.txd = 1'b1; // [RULE15]
                n.ti = 1'b1; // [RULE12]
                ev_tx = 1'b1;
              end
              default: n.tx_st = TX_IDLE;
            endcase
          end
        end
      end
      default: n.tx_ph = q.tx_ph;
    endcase
    // Asynchronous receiver, sampling mid bit at sixteen times the rate.
    if (!q.ren || q.mode == MODE0) begin
      n.rx_st = RX_IDLE; // [RULE9]
    end else if (tk.os_tick) begin
      n.rx_ph = q.rx_ph + 4'h1;
      if (q.rx_st == RX_IDLE) begin
        n.rx_ph = 4'h0;
        if (!rxd_in) begin
          n.rx_st = RX_START;
        end
      end else if (q.rx_ph == OS_MID) begin
        case (q.rx_st)
          RX_START: n.rx_st = rxd_in ? RX_IDLE : RX_DATA;
          RX_DATA: begin
            n.rxsh = {rxd_in, q.rxsh[7:1]}; // [RULE15]
            n.rx_cnt = q.rx_cnt + 3'h1;
            if (q.rx_cnt == BIT_LAST) begin
              n.rx_st = q.mode[1] ? RX_NINTH : RX_STOP; // [RULE1]
            end
          end
          RX_NINTH: begin
            n.rx_st = RX_STOP;
            n.rb8 = rxd_in; // [RULE11]
            if (!q.mp || rxd_in) begin // [RULE8]
              n.rxbuf = q.rxsh;
              n.ri = 1'b1; // [RULE13]
              ev_rx = 1'b1;
            end
          end
          RX_STOP: begin
            n.rx_st = RX_IDLE;
            if (!rxd_in) begin
              n.fe = 1'b1; // [RULE4]
              ev_fe = 1'b1;
            end
            if (!q.mode[1] && (!q.mp || rxd_in)) begin // [RULE7]
              n.rxbuf = q.rxsh;
              n.ri = 1'b1; // [RULE13]
              ev_rx = 1'b1;
              if (!q.mp) begin
                n.rb8 = rxd_in; // [RULE11]
              end
            end
          end
          default: n.rx_st = RX_IDLE;
        endcase
      end
    end
    if (n.rx_st == RX_IDLE) begin
      n.rx_cnt = 3'h0;
    end
    // Events are applied last so a set beats a clear in the same cycle.
    n.stat[S_TX] = n.stat[S_TX] | ev_tx;
    n.stat[S_RX] = n.stat[S_RX] | ev_rx;
    n.stat[S_FE] = n.stat[S_FE] | ev_fe;
    n.irq = |(n.stat & n.mask);
  end

  // Registers all state; the idle line is high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode <= sp0_mode_type'(CTL_RESET[7:6]);
      q.stat <= IRQ_RESET;
      q.mask <= IRQ_RESET;
      q.tx_st <= TX_IDLE;
      q.rx_st <= RX_IDLE;
      q.txd <= 1'b1;
      q.rxo <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign rxd_out = q.rxo;
  assign rxd_oe = q.rxoe;
  assign txd = q.txd;
  assign irq = q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  mode_one_frame_a: assert property (q.tx_st == TX_NINTH |-> q.mode[1]) // [RULE1]
    else $error("ninth bit sent outside modes 2 and 3");
  ninth_tx_bit_a: assert property ($rose(q.tx_st == TX_NINTH) |-> txd == $past(q.tb8)) // [RULE10]
    else $error("ninth transmitted bit differs from control");
  fe_view_mode_a: assert property (wr && paddr == CTL_ADDR && q.fev |=> q.mode[1] == $past(q.mode[1])) // [RULE5]
    else $error("mode changed through frame error view");
  fe_set_a: assert property (tk.os_tick && q.ren && q.mode != MODE0 && q.rx_st == RX_STOP
                             && q.rx_ph == OS_MID && !rxd_in |=> q.fe && q.stat[S_FE]) // [RULE4]
    else $error("bad stop bit did not flag frame error");
  mp_filter_a: assert property (tk.os_tick && q.ren && q.mode[1] && q.mp && q.rx_st == RX_NINTH
                                && q.rx_ph == OS_MID && !rxd_in && !q.ri && !wr |=> !q.ri) // [RULE8]
    else $error("filtered frame set receive done");
  mode1_drop_a: assert property (tk.os_tick && q.ren && q.mode == MODE1 && q.mp && q.rx_st == RX_STOP
                                 && q.rx_ph == OS_MID && !rxd_in && !q.ri && !wr |=> !q.ri) // [RULE7]
    else $error("bad stop frame accepted in mode 1");
  ren_gate_a: assert property (!q.ren |=> q.rx_st == RX_IDLE) // [RULE9]
    else $error("receiver ran while disabled");
  tx_done_a: assert property (q.tx_st == TX_NINTH && tk.os_tick && q.tx_ph == OS_LAST
                              |=> q.ti && q.tx_st == TX_STOP && txd) // [RULE12]
    else $error("transmit done not set after ninth bit");
  buf_read_a: assert property (acc && !pwrite && paddr == BUF_ADDR |=> pready && prdata[7:0] == $past(q.rxbuf)) // [RULE14]
    else $error("data read did not return receive buffer");
  irq_level_a: assert property (|(q.stat & q.mask) |-> irq) // [RULE13]
    else $error("interrupt low with unmasked status");
endmodule

// *** verif/sp0_remote_station.sv ***
// Purpose: Remote serial station on the far side of the port's txd and rxd lines.
// Assumes: One bit lasts BIT_CLKS clocks in both directions.
// Notes: The line idles high between frames, as a pulled-up serial line does.
`timescale 1ns/100ps
module sp0_remote_station #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic       clk,
  input  wire logic       txd,
  input  wire logic       nine,
  output logic            rxd,
  output logic [8:0]      got,
  output logic            got_stop,
  output int              got_cnt
);
  int i;

  // Start idle with nothing received.
  initial begin
    rxd = 1'b1;
    got = 9'h000;
    got_stop = 1'b0;
    got_cnt = 0;
  end

  // Receives one frame, sampling each bit in its middle, least significant bit first.
  always begin
    @(negedge txd);
    got = 9'h000;
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      got[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk);
    got_stop = txd;
    got_cnt++;
  end

  // Sends a low start bit, nb data bits from bit 0 up and a chosen stop level.
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    int k;
    @(posedge clk);
    rxd <= 1'b0;
    for (k = 0; k < nb; k++) begin
      repeat (BIT_CLKS) @(posedge clk);
      rxd <= d[k];
    end
    repeat (BIT_CLKS) @(posedge clk);
    rxd <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
endmodule

// *** verif/serial_port0_control_test.sv ***
// Purpose: Self-checking bench for serial port 0 over APB against a remote station.
// Assumes: Timer ticks every 4 clocks give a 64-clock bit, as mode 2 does.
// Notes: Random bytes come from an 8-bit shift register seeded with 20.
`timescale 1ns/100ps
module serial_port0_control_test;
  logic        clk, rst_n, psel, penable, pwrite, timer1_tick, timer2_tick;
  logic        pready, pslverr, rxd_out, rxd_oe, txd, irq, peer_rxd, rxd_in, nine, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [8:0]  got;
  logic        got_stop;
  logic [7:0]  seed, d, c, m0_got;
  logic [1:0]  tk;
  int          got_cnt, n_fail, samples_checked, m, old;

  sp0_serial_port DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_tick(timer1_tick), .timer2_tick(timer2_tick), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .irq(irq));
  sp0_remote_station #(.BIT_CLKS(64)) peer (.clk(clk), .txd(txd), .nine(nine), .rxd(peer_rxd),
    .got(got), .got_stop(got_stop), .got_cnt(got_cnt));

  // The shared data pin carries the port while it drives, else the station.
  assign rxd_in = rxd_oe ? rxd_out : peer_rxd;

  // Clock generator.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Timer ticks at sixteen times the bit rate.
  always @(posedge clk) begin
    tk <= tk + 2'h1;
    timer1_tick <= (tk == 2'h3);
    timer2_tick <= (tk == 2'h1);
  end

  // Mode 0 data is taken from the data pin at each falling shift clock while the port drives it.
  always @(negedge txd) begin
    if (rxd_oe) begin
      m0_got = {rxd_out, m0_got[7:1]};
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Builds the expected control byte from its fields.
  function automatic logic [7:0] ctl_byte(input logic [1:0] md, input logic mp, input logic ren,
                                          input logic tb8, input logic rb8, input logic ti, input logic ri);
    return {md, mp, ren, tb8, rb8, ti, ri};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  // Waits, bounded, for the station to finish a frame.
  task automatic wait_peer(input int was);
    int n;
    n = 0;
    while (got_cnt == was && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    nine = 1'b0;
    tk = 2'h0;
    timer1_tick = 1'b0;
    timer2_tick = 1'b0;
    seed = 8'h14;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'h0);
    apb(1'b0, 12'hffc, 8'h00);
    chk(32'(err), 32'h1);
    apb(1'b1, sp0_pkg::MASK_ADDR, 8'h01);
    // Transmit a random byte in each asynchronous mode, with a ninth bit in modes 2 and 3.
    for (m = 1; m < 4; m++) begin
      seed = lfsr(seed);
      d = seed;
      c = ctl_byte(m[1:0], 1'b0, 1'b0, seed[0], 1'b0, 1'b0, 1'b0);
      nine = m[1];
      apb(1'b1, sp0_pkg::CTL_ADDR, c);
      old = got_cnt;
      apb(1'b1, sp0_pkg::BUF_ADDR, d);
      wait_peer(old);
      chk(32'(got), 32'({m[1] & c[3], d}));
      chk(32'(got_stop), 32'h1);
      apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
      chk(rd_v, 32'(c | 8'h02));
      chk(32'(irq), 32'h1);
      apb(1'b1, sp0_pkg::STAT_ADDR, 8'h01);
      apb(1'b1, sp0_pkg::CTL_ADDR, c);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      // Let the stop bit finish, since a buffer write while busy is ignored.
      repeat (64) @(posedge clk);
    end
    // Mode 0 fast transmit; the slow period would not finish in the wait.
    seed = lfsr(seed);
    apb(1'b1, sp0_pkg::CTL_ADDR, 8'h20);
    apb(1'b1, sp0_pkg::BUF_ADDR, seed);
    repeat (80) @(posedge clk);
    chk(32'(m0_got), 32'(seed));
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'h22);
    apb(1'b1, sp0_pkg::STAT_ADDR, 8'h01);
    // Mode 1 reception, interrupt masked, then unmasked and cleared.
    nine = 1'b0;
    c = ctl_byte(2'b01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, sp0_pkg::CTL_ADDR, c);
    seed = lfsr(seed);
    peer.send({1'b0, seed}, 8, 1'b1);
    apb(1'b0, sp0_pkg::BUF_ADDR, 8'h00);
    chk(rd_v, 32'(seed));
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'(c | 8'h05));
    chk(32'(irq), 32'h0);
    apb(1'b1, sp0_pkg::MASK_ADDR, 8'h02);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, sp0_pkg::STAT_ADDR, 8'h02);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    // Receiver disabled: a frame leaves the flags alone.
    apb(1'b1, sp0_pkg::CTL_ADDR, 8'h40);
    peer.send(9'h0a5, 8, 1'b1);
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'h40);
    // Mode 1 filter with a bad stop bit, then the frame error view.
    apb(1'b1, sp0_pkg::CTL_ADDR, 8'h70);
    peer.send(9'h03c, 8, 1'b0);
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'h70);
    apb(1'b0, sp0_pkg::STAT_ADDR, 8'h00);
    chk(rd_v, 32'h4);
    apb(1'b1, sp0_pkg::CFG_ADDR, 8'h01);
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'hf0);
    apb(1'b1, sp0_pkg::CTL_ADDR, 8'hf0);
    apb(1'b1, sp0_pkg::CFG_ADDR, 8'h00);
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'h70);
    apb(1'b1, sp0_pkg::CFG_ADDR, 8'h01);
    apb(1'b1, sp0_pkg::CTL_ADDR, 8'h70);
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'h70);
    apb(1'b1, sp0_pkg::CFG_ADDR, 8'h00);
    // Mode 3 address filter: ninth bit 0 is dropped, ninth bit 1 is taken.
    apb(1'b1, sp0_pkg::CTL_ADDR, 8'hf0);
    peer.send(9'h055, 9, 1'b1);
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'hf0);
    seed = lfsr(seed);
    peer.send({1'b1, seed}, 9, 1'b1);
    apb(1'b0, sp0_pkg::CTL_ADDR, 8'h00);
    chk(rd_v, 32'hf5);
    apb(1'b0, sp0_pkg::BUF_ADDR, 8'h00);
    chk(rd_v, 32'(seed));
    tally_and_finish();
  end
endmodule
